// ### core/dsps_seq.sv
// dual slope converter timing, counting and backplane core
`timescale 1ns/1ps
`default_nettype none

// Operation
// - count enable is the oscillator clock divided by four.
// - full cycle is exactly 4000 counts, 16000 oscillator pulses.
// - cycle length never depends on input magnitude.
// - auto-zero lasts 1000 to 3000 counts.
// - unused reference integrate time is added to auto-zero.
// - signal integrate lasts exactly 1000 counts.
// - reference integrate runs 0 to 2000 counts, ends on comparator zero.
// - minus indicator active for negative input, follows input sense.
// - full scale reading equals 2000 counts.
// - backplane toggles to give oscillator divided by 800.
// - sign decided at end of signal integrate, even below one count.
module dsps_seq (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cmp_zero,      // integrator returned to zero
  input  wire logic              cmp_neg,       // integrator sign after signal integrate
  output logic                   az_en,         // auto-zero switches closed
  output logic                   si_en,         // input connected to integrator
  output logic                   ri_en,         // reference connected to integrator
  output logic                   ref_flip,      // reference applied in opposite sense
  output logic [dsps_pkg::CNT_W-1:0] reading,
  output logic                   minus,
  output logic                   over_range,
  output logic                   reading_valid,
  output logic                   backplane
);

  // registered state and its next value
  dsps_pkg::dsps_state_t s_q;
  dsps_pkg::dsps_state_t s_d;

  // count tick and wrap events
  logic                       tick;
  logic                       bp_wrap;
  logic                       cyc_wrap;

  // phase decodes of the registered phase
  logic                       in_az;
  logic                       in_si;
  logic                       in_ri;

  // phase end events, all on count ticks
  logic                       si_done;
  logic                       ri_zero;
  logic                       ri_full;
  logic                       ri_done;

  // counter values one step on
  logic [dsps_pkg::PRE_W-1:0] pre_inc;
  logic [dsps_pkg::CNT_W-1:0] cyc_inc;
  logic [dsps_pkg::CNT_W-1:0] ph_inc;
  logic [dsps_pkg::BP_W-1:0]  bp_inc;

  // one count per four oscillator pulses
  assign tick     = (s_q.pre == dsps_pkg::PRE_LAST);

  // half period of 400 pulses gives divide by 800
  assign bp_wrap  = (s_q.bp_cnt == dsps_pkg::BP_LAST);

  // last count of the 4000-count cycle
  assign cyc_wrap = tick && (s_q.cyc == dsps_pkg::CYCLE_LAST);

  // phase decodes
  assign in_az    = (s_q.phase == dsps_pkg::DSPS_AZ);
  assign in_si    = (s_q.phase == dsps_pkg::DSPS_SI);
  assign in_ri    = (s_q.phase == dsps_pkg::DSPS_RI);

  // signal integrate ends on its 1000th count
  assign si_done  = tick && in_si && (s_q.ph_cnt == dsps_pkg::SI_LAST);

  // reference integrate ends on zero or full allotment
  assign ri_zero  = tick && in_ri && cmp_zero;
  assign ri_full  = tick && in_ri && (s_q.ph_cnt == dsps_pkg::RI_LAST);

  // zero wins over a full allotment on the same count
  assign ri_done  = ri_zero || ri_full;

  // counter increments at register width
  assign pre_inc  = s_q.pre + 1'b1;
  assign cyc_inc  = s_q.cyc + 1'b1;
  assign ph_inc   = s_q.ph_cnt + 1'b1;
  assign bp_inc   = s_q.bp_cnt + 1'b1;

  // next state: counters, phase moves and latched results
  always_comb begin
    // hold by default, new reading pulse cleared
    s_d       = s_q;
    s_d.valid = 1'b0;

    // prescaler runs on every oscillator pulse
    s_d.pre   = pre_inc;

    // backplane toggles at each half period
    if (bp_wrap) begin
      s_d.bp_cnt = '0;
      s_d.bp     = ~s_q.bp;
    end else begin
      s_d.bp_cnt = bp_inc;
    end

    // cycle position wraps at 4000 counts
    // wrap is fixed, independent of reading
    if (cyc_wrap) begin
      s_d.cyc = '0;
    end else if (tick) begin
      s_d.cyc = cyc_inc;
    end

    // counts spent in the current phase
    if (tick) begin
      s_d.ph_cnt = ph_inc;
    end

    // phase sequence, moves on count ticks only
    if (tick) begin
      unique case (s_q.phase)
        dsps_pkg::DSPS_AZ: begin
          // auto-zero ends only with the cycle, after at least 1000 counts
          // leftover reference time stays in auto-zero
          if (cyc_wrap) begin
            s_d.phase  = dsps_pkg::DSPS_SI;
            s_d.ph_cnt = '0;
          end
        end

        dsps_pkg::DSPS_SI: begin
          if (si_done) begin
            s_d.phase  = dsps_pkg::DSPS_RI;
            s_d.ph_cnt = '0;
          end
        end

        dsps_pkg::DSPS_RI: begin
          // stop on zero crossing or at 2000 counts
          if (ri_done) begin
            s_d.phase  = dsps_pkg::DSPS_AZ;
            s_d.ph_cnt = '0;
          end
        end

        // unused phase code falls back to auto-zero
        default: begin
          s_d.phase  = dsps_pkg::DSPS_AZ;
          s_d.ph_cnt = '0;
        end
      endcase
    end

    // sign captured at end of signal integrate
    if (si_done) begin
      s_d.neg = cmp_neg;
    end

    // latch magnitude at reference end, flag over range
    if (ri_zero) begin
      s_d.reading = s_q.ph_cnt;
      s_d.over    = 1'b0;
    end else if (ri_full) begin
      s_d.reading = dsps_pkg::RI_FULL;
      s_d.over    = 1'b1;
    end

    // one-cycle new reading pulse
    if (ri_done) begin
      s_d.valid = 1'b1;
    end
  end

  // state register
  // first auto-zero after reset lasts the minimum 1000 counts
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{
        phase:   dsps_pkg::DSPS_AZ,
        cyc:     dsps_pkg::AZ_START,
        default: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // auto-zero switches closed
  assign az_en         = in_az;

  // input connected to the integrator
  assign si_en         = in_si;

  // reference connected to the integrator
  assign ri_en         = in_ri;

  // reference sense follows the latched sign
  assign ref_flip      = s_q.neg;

  // latched magnitude
  assign reading       = s_q.reading;

  assign minus         = s_q.neg;

  // latched over range flag
  assign over_range    = s_q.over;

  // new reading pulse
  assign reading_valid = s_q.valid;

  // backplane square wave
  assign backplane     = s_q.bp;

endmodule // dsps_seq

`default_nettype wire

// ### core/dsps_pkg.sv
// constants and types for the dual slope phase sequencer
package dsps_pkg;
  localparam int unsigned CLK_DIV         = 4;     // oscillator pulses per count
  localparam int unsigned CYCLE_COUNTS    = 4000;  // counts per full measurement cycle
  localparam int unsigned SI_COUNTS       = 1000;  // fixed signal integrate length
  localparam int unsigned RI_MAX_COUNTS   = 2000;  // reference integrate allotment
  localparam int unsigned AZ_MIN_COUNTS   = 1000;  // auto-zero floor
  localparam int unsigned BP_DIV          = 800;   // backplane divide ratio
  localparam int unsigned BP_HALF         = BP_DIV / 2;
  localparam int unsigned CNT_W           = 12;
  localparam int unsigned PRE_W           = 2;
  localparam int unsigned BP_W            = 9;

  localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_COUNTS - 1);
  localparam logic [CNT_W-1:0] SI_LAST    = CNT_W'(SI_COUNTS - 1);
  localparam logic [CNT_W-1:0] RI_LAST    = CNT_W'(RI_MAX_COUNTS - 1);
  localparam logic [CNT_W-1:0] RI_FULL    = CNT_W'(RI_MAX_COUNTS);
  localparam logic [CNT_W-1:0] AZ_LAST    = CNT_W'(AZ_MIN_COUNTS - 1);
  localparam logic [CNT_W-1:0] AZ_START   = CNT_W'(CYCLE_COUNTS - AZ_MIN_COUNTS); // reset position
  localparam logic [PRE_W-1:0] PRE_LAST   = PRE_W'(CLK_DIV - 1);
  localparam logic [BP_W-1:0]  BP_LAST    = BP_W'(BP_HALF - 1);

  typedef enum logic [1:0] {
    DSPS_AZ,
    DSPS_SI,
    DSPS_RI
  } dsps_phase_t;

  typedef struct packed {
    dsps_phase_t      phase;
    logic [PRE_W-1:0] pre;       // divide-by-four prescaler
    logic [CNT_W-1:0] cyc;       // position within the 4000-count cycle
    logic [CNT_W-1:0] ph_cnt;    // counts spent in current phase
    logic [CNT_W-1:0] reading;   // latched magnitude
    logic             neg;       // latched polarity
    logic             over;      // latched over range
    logic             valid;     // one-cycle new reading pulse
    logic [BP_W-1:0]  bp_cnt;    // backplane half-period counter
    logic             bp;        // backplane level
  } dsps_state_t;
endpackage : dsps_pkg

// ### dv/dsps_analog_model.sv
// integrator and comparator model at the converter's far side
`timescale 1ns/1ps
`default_nettype none
module dsps_analog_model (
  input  wire logic        clk,
  input  wire logic        ri_en,
  input  wire logic        neg,
  input  wire logic [11:0] n,
  output logic             cmp_zero,
  output logic             cmp_neg
);
  int k = 0;
  initial cmp_zero = 1'b0;
  initial cmp_neg = 1'b0;
  always @(negedge clk) begin
    k = ri_en ? k + 1 : 0;
    cmp_zero <= ri_en ? (k >= 4 * n + 1) : ~cmp_zero;  // junk outside reference phase
    cmp_neg <= neg;
  end
endmodule // dsps_analog_model
`default_nettype wire

// ### dv/dsps_seq_monitor.sv
// assertion checker for the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module dsps_seq_monitor (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       si_en,
  input wire logic                       ri_en,
  input wire logic                       az_en,
  input wire logic                       minus,
  input wire logic                       cmp_neg,
  input wire logic                       over_range,
  input wire logic                       reading_valid,
  input wire logic                       backplane,
  input wire logic [dsps_pkg::CNT_W-1:0] reading
);
  logic [14:0] c_q;
  logic [13:0] a_q;
  logic [8:0]  b_q;
  logic        bp_q;
  logic        seen_q;
  // clocks since integrate start, spent in auto-zero and since backplane edge
  always_ff @(posedge clk) begin
    bp_q   <= backplane;
    c_q    <= rst ? 15'h0 : $rose(si_en) ? 15'h1 : c_q + 15'h1;
    a_q    <= rst ? 14'h0 : az_en ? a_q + 14'h1 : 14'h0;
    b_q    <= rst ? 9'h0 : (backplane != bp_q) ? 9'h1 : b_q + 9'h1;
    seen_q <= rst ? 1'b0 : seen_q | $rose(si_en);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_cycle_len: assert property ($rose(si_en) && seen_q |-> c_q == 15'h3E80) else $error("cycle");
  a_si_len: assert property ($fell(si_en) |-> c_q == 15'hFA0 && ri_en) else $error("si len");
  a_ri_max: assert property (ri_en |-> c_q <= 15'h2EDF) else $error("ri len");
  a_phase_one: assert property ($onehot({az_en, si_en, ri_en})) else $error("phase");
  a_az_follows: assert property ($fell(ri_en) |-> az_en && reading_valid) else $error("end");
  a_over_flag: assert property (reading_valid |-> over_range == (reading == dsps_pkg::RI_FULL))
    else $error("over");
  a_sign_take: assert property ($fell(si_en) |-> minus == $past(cmp_neg)) else $error("sign");
  a_bp_half: assert property (backplane != bp_q |-> b_q == 9'h190) else $error("bp");
  a_az_len: assert property ($fell(az_en) |-> a_q >= 14'hFA0 && a_q <= 14'h2EE0)
    else $error("az len");
  a_valid_pulse: assert property (reading_valid |=> !reading_valid) else $error("valid");
endmodule // dsps_seq_monitor
bind dsps_seq dsps_seq_monitor i_mon (.clk, .rst, .si_en, .ri_en, .az_en, .minus, .cmp_neg,
  .over_range, .reading_valid, .backplane, .reading);
`default_nettype wire

// ### dv/dsps_seq_test.sv
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module dsps_seq_test;
  logic clk = 0, rst = 1, neg = 1, cmp_zero, cmp_neg, az_en, si_en, ri_en, ref_flip, minus;
  logic over_range, reading_valid, backplane;
  logic [11:0] reading, n = 0;
  logic [31:0] lf = 32'h6F24DAA1;
  int n_fail = 0, check_count = 0, want[$] = '{0, 2000, 1999};
  always #2 clk = ~clk;
  dsps_seq i_dut (.clk, .rst, .cmp_zero, .cmp_neg, .az_en, .si_en, .ri_en, .ref_flip,
    .reading, .minus, .over_range, .reading_valid, .backplane);
  dsps_analog_model i_ana (.clk, .ri_en, .n, .neg, .cmp_zero, .cmp_neg);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  // boundary readings, then random ones
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    repeat (2) begin
      lf = lfsr(lf);
      want.push_back(lf % 2001);
    end
    foreach (want[i]) begin
      n = 12'(want[i]);
      neg = (i == 0) | lf[i];
      for (int t = 0; t < 30000 && reading_valid !== 1'b1; t++) @(negedge clk);
      check("valid", reading_valid, 1);
      check("reading", reading, n);
      check("over", over_range, 12'(want[i] >= 2000));
      check("minus", minus, neg);
      check("flip", ref_flip, neg);
      @(negedge clk);
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule // dsps_seq_test
`default_nettype wire
